// File: ebsc_bank_switch.sv
/*
 * Bank switch sequencer, clock-out divider, keeper control and the
 * bank switch control register behind an AHB-Lite slave.
 * Assumes the CPU holds acc_req_i until acc_done_o, and that the
 * wide host port select pin is a static board strap.
 */
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ebsc_bank_switch #(
    parameter int ADDR_W = 23
) (
    input  wire logic                sys_clk_i,
    input  wire logic                arst_n_i,
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    output logic [31:0]              hrdata_o,
    input  wire logic                acc_req_i,
    input  wire logic                acc_prog_i,
    input  wire logic                acc_write_i,
    input  wire logic [ADDR_W-1:0]   acc_addr_i,
    output logic                     acc_done_o,
    output logic [ADDR_W-1:0]        mem_addr_o,
    output logic                     mem_prog_o,
    output logic                     mem_write_o,
    output logic                     memory_strobe_n_o,
    output logic                     divided_clock_output_o,
    input  wire logic                interrupt_acknowledge_out_n_i,
    output logic                     interrupt_acknowledge_out_n_o,
    input  wire logic                wide_host_port_select_i,
    output logic                     data_bus_keeper_o,
    output logic                     addr_bus_keeper_o,
    output logic                     host_data_keeper_o
);
    import ebsc_pkg::*;

    localparam int TAG_W = ADDR_W - BANK_LSB;

    initial begin
        if (ADDR_W <= BANK_LSB || ADDR_W > 32) begin
            $error("ADDR_W must exceed the bank bit and fit 32 bits");
        end
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic              consecutive_switch_mode;
        logic [1:0]        div;
        logic              ackoff;
        logic              hkeep;
        logic              dkeep;
        logic              wr_pend;
        logic              wr_hit;
        logic [31:0]       rdata;
        logic [1:0]        wide_sync;
        logic [1:0]        div_cnt;
        logic              clk_hi;
        ebsc_phase_e       phase;
        logic [TAG_W-1:0]  tag_bank;
        logic              tag_prog;
        logic [ADDR_W-1:0] addr;
        logic              prog;
        logic              write;
        logic              strobe_n;
        logic              done;
    } ebsc_state_s;

    ebsc_state_s st_reg;
    ebsc_state_s st_next;

    // Register view; reserved bits are constant zero
    function automatic logic [15:0] ebsc_view(input ebsc_state_s s);
        logic [15:0] v;
        v = RSVD_READ;
        v[CONSECUTIVE_SWITCH_MODE_BIT] = s.consecutive_switch_mode;
        v[DIV_MSB:DIV_LSB] = s.div;
        v[ACKOFF_BIT] = s.ackoff;
        v[HKEEP_BIT] = s.hkeep;
        v[DKEEP_BIT] = s.dkeep;
        return v;
    endfunction : ebsc_view

    logic             tick;
    logic             accept;
    logic             take;
    logic             change;
    logic [TAG_W-1:0] req_bank;

    assign req_bank = acc_addr_i[ADDR_W-1:BANK_LSB];
    // Bank or space change against the last access
    assign change = (req_bank != st_reg.tag_bank)
                  || (acc_prog_i != st_reg.tag_prog);
    // End of one clock-out period; >= recovers from a divide change
    assign tick = (st_reg.div_cnt >= st_reg.div);
    assign accept = hsel_i && hready_i && (htrans_i == HTRANS_NSEQ);
    // done blocks a second take of a request that is still dropping
    assign take = tick && (st_reg.phase == EBSC_IDLE) && acc_req_i
                  && !st_reg.done;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.wide_sync = {st_reg.wide_sync[0], wide_host_port_select_i};

        // Register write in its data phase
        if (st_reg.wr_pend && st_reg.wr_hit) begin
            st_next.consecutive_switch_mode = hwdata_i[CONSECUTIVE_SWITCH_MODE_BIT];
            st_next.div    = hwdata_i[DIV_MSB:DIV_LSB];
            st_next.ackoff = hwdata_i[ACKOFF_BIT];
            st_next.hkeep  = hwdata_i[HKEEP_BIT];
            st_next.dkeep  = hwdata_i[DKEEP_BIT];
        end
        st_next.wr_pend = accept && hwrite_i;
        st_next.wr_hit  = haddr_i == BANK_SWITCH_CONTROL_BYTE_ADDR;
        // Read data sampled after any write in flight lands
        if (accept && !hwrite_i) begin
            st_next.rdata = (haddr_i == BANK_SWITCH_CONTROL_BYTE_ADDR)
                          ? {16'h0000, ebsc_view(st_next)}
                          : UNMAPPED_READ;
        end

        // Clock-out divider: high in the first half of the period, rounded up for divide by three
        st_next.div_cnt = tick ? 2'h0 : st_reg.div_cnt + 2'h1;
        st_next.clk_hi  = st_next.div_cnt <= {1'b0, st_reg.div[1]};

        // Sequencer steps once per clock-out period
        if (tick) begin
            unique case (st_reg.phase)
                EBSC_IDLE: begin
                    if (take) begin
                        st_next.addr  = acc_addr_i;
                        st_next.prog  = acc_prog_i;
                        st_next.write = acc_write_i;
                        st_next.tag_bank = req_bank;
                        st_next.tag_prog = acc_prog_i;
                        if (acc_write_i) begin
                            st_next.phase = EBSC_STROBE;
                        end else if (st_reg.consecutive_switch_mode) begin
                            st_next.phase = EBSC_START;
                        end else if (change) begin
                            st_next.phase = EBSC_GAP;
                        end else begin
                            st_next.phase = EBSC_STROBE;
                        end
                    end
                end
                EBSC_GAP: begin
                    st_next.phase = EBSC_STROBE;
                end
                EBSC_START: begin
                    st_next.phase = EBSC_STROBE;
                end
                EBSC_STROBE: begin
                    if (st_reg.consecutive_switch_mode && !st_reg.write) begin
                        st_next.phase = EBSC_TRAIL;
                    end else begin
                        st_next.phase = EBSC_IDLE;
                        st_next.done  = 1'b1;
                    end
                end
                EBSC_TRAIL: begin
                    st_next.phase = EBSC_IDLE;
                    st_next.done  = 1'b1;
                end
                default: begin
                    st_next.phase = EBSC_IDLE;
                end
            endcase
        end
        // Strobe only in the access cycle itself
        st_next.strobe_n = st_next.phase != EBSC_STROBE;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '{consecutive_switch_mode: CONSECUTIVE_SWITCH_MODE_RST, div: DIV_RST,
                        ackoff: ACKOFF_RST, hkeep: HKEEP_RST,
                        dkeep: DKEEP_RST, phase: EBSC_IDLE,
                        strobe_n: 1'b1, clk_hi: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Slave never stalls and never errors
    assign hreadyout_o = 1'b1;
    assign hresp_o     = HRESP_OKAY;
    assign hrdata_o    = st_reg.rdata;
    assign acc_done_o  = st_reg.done;
    assign mem_addr_o  = st_reg.addr;
    assign mem_prog_o  = st_reg.prog;
    assign mem_write_o = st_reg.write;
    assign memory_strobe_n_o = st_reg.strobe_n;
    // Divide by one passes the clock itself; a flop cannot reach that
    // rate, so a code change can shorten one clock-out pulse
    assign divided_clock_output_o = (st_reg.div == 2'h0) ? sys_clk_i
                                                         : st_reg.clk_hi;
    // Off function holds the acknowledge output inactive
    assign interrupt_acknowledge_out_n_o = interrupt_acknowledge_out_n_i
                                         | st_reg.ackoff;
    // Keeper selection by strap and keeper bits
    assign data_bus_keeper_o  = st_reg.dkeep;
    assign host_data_keeper_o = st_reg.hkeep
                              | st_reg.wide_sync[1];
    assign addr_bus_keeper_o  = st_reg.wide_sync[1] && st_reg.dkeep
                              && st_reg.hkeep;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking ebsc_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_DIVIDED_CLOCK_OUTPUT_DIV4: assert property (
        (st_reg.div == 2'h3) && $stable(st_reg.div) && tick
        |=> st_reg.clk_hi ##1 (st_reg.clk_hi || st_reg.div != 2'h3)
            ##1 (!st_reg.clk_hi || st_reg.div != 2'h3)
            ##1 (!st_reg.clk_hi || st_reg.div != 2'h3))
        else $error("clock out not divided by four");
    AST_CONSECUTIVE_SWITCH_MODE_TRAIL: assert property (
        tick && st_reg.phase == EBSC_STROBE && st_reg.consecutive_switch_mode
        && !st_reg.write |=> st_reg.phase == EBSC_TRAIL)
        else $error("consecutive read missing trailing cycle");
    AST_CONSECUTIVE_SWITCH_MODE_START: assert property (
        take && st_reg.consecutive_switch_mode && !acc_write_i
        |=> st_reg.phase == EBSC_START && memory_strobe_n_o)
        else $error("consecutive read missing starting cycle");
    AST_GAP_ON_CHANGE: assert property (
        take && !st_reg.consecutive_switch_mode && !acc_write_i && change
        |=> st_reg.phase == EBSC_GAP && memory_strobe_n_o)
        else $error("bank change without idle strobe cycle");
    AST_NO_GAP_SAME: assert property (
        take && !st_reg.consecutive_switch_mode && !change
        |=> st_reg.phase == EBSC_STROBE && !memory_strobe_n_o)
        else $error("same bank read got an extra cycle");
    AST_TAG_UPDATE: assert property (
        take |=> st_reg.tag_bank == $past(req_bank)
                 && st_reg.tag_prog == $past(acc_prog_i))
        else $error("bank record not updated");
    AST_ADDR_KEEP_OFF: assert property (
        !st_reg.wide_sync[1] |-> !addr_bus_keeper_o)
        else $error("address keeper on with narrow host port");
    AST_WRITE_LANDS: assert property (
        accept && hwrite_i && haddr_i == BANK_SWITCH_CONTROL_BYTE_ADDR
        ##1 hready_i |=> st_reg.div == $past(hwdata_i[DIV_MSB:DIV_LSB]))
        else $error("control register write lost");
    AST_RSVD_ZERO: assert property (
        hrdata_o[11:3] == 9'h000 && !hrdata_o[0])
        else $error("reserved bits read nonzero");
    AST_ACK_OFF: assert property (
        st_reg.ackoff |-> interrupt_acknowledge_out_n_o)
        else $error("acknowledge output not held off");


    // ************************************************************
    // Assertions on sequencing, divider, keepers, acknowledge and read data
    // ************************************************************
    // Done is a single pulse, so the CPU never sees one access twice
    AST_DONE_PULSE: assert property (
        acc_done_o |=> !acc_done_o)
        else $error("access done held longer than one cycle");

    // Writes go straight to the strobe period, never a gap
    AST_WRITE_NO_GAP: assert property (
        take && acc_write_i
        |=> st_reg.phase == EBSC_STROBE && !memory_strobe_n_o)
        else $error("write received an extra cycle");

    // The gap period is followed by the strobe itself
    AST_GAP_TO_STROBE: assert property (
        tick && st_reg.phase == EBSC_GAP
        |=> st_reg.phase == EBSC_STROBE && !memory_strobe_n_o)
        else $error("gap not followed by strobe");

    // Strobe stays inactive for the whole gap period
    AST_GAP_STROBE_OFF: assert property (
        st_reg.phase == EBSC_GAP |-> memory_strobe_n_o)
        else $error("strobe active during gap cycle");

    // Strobe may only rise at the end of a clock-out period
    AST_STROBE_HELD: assert property (
        !memory_strobe_n_o && !tick |=> !memory_strobe_n_o)
        else $error("strobe shorter than one clock-out period");

    // Trailing period ends the consecutive-mode read
    AST_TRAIL_DONE: assert property (
        tick && st_reg.phase == EBSC_TRAIL
        |=> acc_done_o && st_reg.phase == EBSC_IDLE)
        else $error("trailing cycle did not finish the read");

    // Divide by two: one high and one low processor cycle
    AST_DIVIDED_CLOCK_OUTPUT_DIV2: assert property (
        (st_reg.div == 2'h1) && $stable(st_reg.div) && tick
        |=> st_reg.clk_hi ##1 (!st_reg.clk_hi || st_reg.div != 2'h1))
        else $error("clock out not divided by two");

    // Wide strap forces the host data keeper on
    AST_HOST_KEEP_WIDE: assert property (
        st_reg.wide_sync[1] |-> host_data_keeper_o)
        else $error("host keeper off with wide host port");

    // Address keeper needs both keeper bits set
    AST_ADDR_KEEP_BOTH: assert property (
        addr_bus_keeper_o |-> st_reg.dkeep && st_reg.hkeep)
        else $error("address keeper on without both bits");

    // With the off function disabled the acknowledge passes through
    AST_ACK_PASS: assert property (
        !st_reg.ackoff |-> interrupt_acknowledge_out_n_o == interrupt_acknowledge_out_n_i)
        else $error("acknowledge blocked while off function disabled");

    // Unmapped reads return zero in their data phase
    AST_UNMAPPED_ZERO: assert property (
        accept && !hwrite_i && haddr_i != BANK_SWITCH_CONTROL_BYTE_ADDR
        |=> hrdata_o == UNMAPPED_READ)
        else $error("unmapped read returned nonzero data");

    // Address bus only moves when a new access is taken
    AST_MEM_HOLD: assert property (
        !take |=> $stable(mem_addr_o))
        else $error("memory address moved without an access");

    COV_DIV_ONE_ACCESS: cover property (take && st_reg.div == 2'h0);
    COV_GAP_READ: cover property (st_reg.phase == EBSC_GAP);
    COV_CONSECUTIVE_SWITCH_MODE_READ: cover property (st_reg.phase == EBSC_TRAIL);
    COV_WRITE: cover property (take && acc_write_i);
    COV_REG_WRITE: cover property (st_reg.wr_pend && st_reg.wr_hit);
endmodule : ebsc_bank_switch

// File: ebsc_pkg.sv
/*
 * Constants, field layout and sequencer states of the external bank
 * switch control block.
 * Assumes one 20 MHz processor clock and an AHB-Lite register port.
 */
package ebsc_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  BANK_SWITCH_CONTROL_INDEX     = 8'h29;
    localparam logic [31:0] BANK_SWITCH_CONTROL_BYTE_ADDR = {22'h0, BANK_SWITCH_CONTROL_INDEX, 2'h0};
    localparam logic [15:0] RSVD_READ      = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CONSECUTIVE_SWITCH_MODE_BIT  = 15;
    localparam int DIV_LSB     = 13;
    localparam int DIV_MSB     = 14;
    localparam int ACKOFF_BIT  = 12;
    localparam int HKEEP_BIT   = 2;
    localparam int DKEEP_BIT   = 1;
    localparam logic       CONSECUTIVE_SWITCH_MODE_RST = 1'h1;
    localparam logic [1:0] DIV_RST    = 2'h3;
    localparam logic       ACKOFF_RST = 1'h1;
    localparam logic       HKEEP_RST  = 1'h0;
    localparam logic       DKEEP_RST  = 1'h0;

    // ************************************************************
    // Bus and sequencer
    // ************************************************************
    localparam int        BANK_LSB    = 15;  // 32K-word banks
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
    localparam logic       HRESP_OKAY  = 1'h0;

    typedef enum logic [2:0] {
        EBSC_IDLE   = 3'h0,
        EBSC_GAP    = 3'h1,
        EBSC_START  = 3'h3,
        EBSC_STROBE = 3'h2,
        EBSC_TRAIL  = 3'h6
    } ebsc_phase_e;
endpackage : ebsc_pkg

// File: ebsc_mem_model.sv
/*
 * External memory side model: times each strobe and counts pulses,
 * and carries the board strap for the host port width.
 * Assumes one processor clock and a registered active-low strobe.
 */
`timescale 1ns/1ps
module ebsc_mem_model (
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       memory_strobe_n_i,
    input  wire logic       strap_i,
    output logic            wide_host_port_select_o,
    output logic [7:0]      low_len_o,
    output logic [7:0]      n_strobes_o
);
    // ************************************************************
    // Strap and strobe monitor
    // ************************************************************
    logic [7:0] run_cnt;
    // Strap is static on a board; bench moves it on every step of the keeper test
    assign wide_host_port_select_o = strap_i;
    // Width is latched when the strobe rises, so a stuck strobe shows
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_cnt     <= 8'h00;
            low_len_o   <= 8'h00;
            n_strobes_o <= 8'h00;
        end else if (!memory_strobe_n_i) begin
            run_cnt <= run_cnt + 8'h01;
        end else if (run_cnt != 8'h00) begin
            low_len_o   <= run_cnt;
            n_strobes_o <= n_strobes_o + 8'h01;
            run_cnt     <= 8'h00;
        end
    end
endmodule : ebsc_mem_model

// File: testbench.sv
/*
 * Self-checking bench for the bank switch block: register port,
 * clock-out divider, acknowledge gate, keepers and access timing.
 * Assumes a 50 ns clock and the register at its word byte address.
 */
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench;
    import ebsc_pkg::*;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic sys_clk_i = 1'b0, arst_n_i = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, acc_req, acc_prog, acc_write;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [22:0] acc_addr, mem_addr;
    logic done, strb_n, clk_out, interrupt_acknowledge_out_n, interrupt_acknowledge_out_o, strap, wide;
    logic dk, ak, hk, mem_prog, mem_write;
    logic [7:0] low_len, n_strb;
    logic [8:0] rec;
    logic [15:0] ctl;
    int fails = 0, n_checks = 0, seed = 32'ha3ea, clk_cnt = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge clk_out) clk_cnt++;
    ebsc_bank_switch i_ebsc_bank_switch (.sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .hrdata_o(hrdata), .acc_req_i(acc_req),
        .acc_prog_i(acc_prog), .acc_write_i(acc_write),
        .acc_addr_i(acc_addr), .acc_done_o(done), .mem_addr_o(mem_addr),
        .mem_prog_o(mem_prog), .mem_write_o(mem_write),
        .memory_strobe_n_o(strb_n), .divided_clock_output_o(clk_out),
        .interrupt_acknowledge_out_n_i(interrupt_acknowledge_out_n), .interrupt_acknowledge_out_n_o(interrupt_acknowledge_out_o),
        .wide_host_port_select_i(wide), .data_bus_keeper_o(dk),
        .addr_bus_keeper_o(ak), .host_data_keeper_o(hk));
    ebsc_mem_model i_ebsc_mem_model (.sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i), .memory_strobe_n_i(strb_n), .strap_i(strap),
        .wide_host_port_select_o(wide), .low_len_o(low_len),
        .n_strobes_o(n_strb));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic report_and_stop;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask : check_val
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_rdy
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NSEQ;
        wait_rdy();
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        wait_rdy();
        rd = hrdata;
        `CHK(hresp, HRESP_OKAY);
    endtask : ahb
    // Periods per access from mode, direction and record change
    function automatic int exp_periods(logic c, logic w, logic chg);
        if (w) return 1;
        if (c) return 3;
        return chg ? 2 : 1;
    endfunction : exp_periods
    task automatic acc(input logic p, input logic w, input logic [22:0] a);
        int k, n, pp;
        logic [7:0] ns;
        pp = ctl[14:13] + 1;
        k = exp_periods(ctl[15], w, {a[22:15], p} != rec) * pp;
        rec = {a[22:15], p};
        ns = n_strb;
        acc_req <= 1'b1; acc_prog <= p; acc_write <= w; acc_addr <= a;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (done !== 1'b1 && n < 200);
        if (n >= 200) begin
            fails++;
            report_and_stop();
        end
        acc_req <= 1'b0;
        `CHK(n >= k + 1 && n <= k + pp + 2, 1);
        @(posedge sys_clk_i);
        `CHK(low_len, pp);
        `CHK(n_strb, ns + 8'h01);
        `CHK({mem_addr, mem_prog, mem_write}, {a, p, w});
    endtask : acc
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {hsel, hwrite, acc_req, acc_prog, acc_write, strap} = '0;
        {haddr, hwdata, acc_addr, htrans} = '0;
        hsize = 3'h2; interrupt_acknowledge_out_n = 1'b1; rec = '0;
        void'($random(seed));
        repeat (10) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        ahb(1'b0, BANK_SWITCH_CONTROL_BYTE_ADDR, '0);
        `CHK(rd, 32'h0000_f000);
        ahb(1'b1, BANK_SWITCH_CONTROL_BYTE_ADDR, 32'hffff_ffff);
        ahb(1'b1, 32'h0000_00a0, 32'h0000_0000);
        ahb(1'b0, 32'h0000_00a0, '0);
        `CHK(rd, 32'h0);
        ahb(1'b0, BANK_SWITCH_CONTROL_BYTE_ADDR, '0);
        `CHK(rd, 32'h0000_f006);
        $display("test register done");
        for (int d = 0; d < 4; d++) begin
            int c0;
            ctl = {1'b0, 2'(d), 13'h1000};
            ahb(1'b1, BANK_SWITCH_CONTROL_BYTE_ADDR, {16'h0, ctl});
            @(negedge sys_clk_i);
            c0 = clk_cnt;
            repeat (24) @(negedge sys_clk_i);
            `CHK(clk_cnt - c0, 24 / (d + 1));
            @(posedge sys_clk_i);
        end
        $display("test divider done");
        for (int i = 0; i < 16; i++) begin
            ctl = {3'h0, 1'($random(seed)), 9'h0, 3'(i >> 1)};
            strap <= i[0];
            interrupt_acknowledge_out_n <= 1'($random(seed));
            ahb(1'b1, BANK_SWITCH_CONTROL_BYTE_ADDR, {16'h0, ctl});
            repeat (4) @(posedge sys_clk_i);
            `CHK(interrupt_acknowledge_out_o, interrupt_acknowledge_out_n | ctl[12]);
            `CHK(dk, ctl[1]);
            `CHK(hk, ctl[2] | strap);
            `CHK(ak, strap & ctl[1] & ctl[2]);
        end
        $display("test keepers done");
        ctl = 16'h0000;
        ahb(1'b1, BANK_SWITCH_CONTROL_BYTE_ADDR, 32'h0);
        acc(1'b0, 1'b0, 23'h000010);
        acc(1'b0, 1'b0, 23'h007fff);
        acc(1'b1, 1'b0, 23'h000020);
        acc(1'b1, 1'b0, 23'h018000);
        acc(1'b0, 1'b0, 23'h018000);
        acc(1'b0, 1'b1, 23'h030000);
        acc(1'b0, 1'b0, 23'h030001);
        for (int i = 0; i < 48; i++) begin
            if (i % 8 == 0) begin
                ctl = {3'($random(seed)), 13'h0};
                ahb(1'b1, BANK_SWITCH_CONTROL_BYTE_ADDR, {16'h0, ctl});
            end
            acc(1'($random(seed)), 1'($random(seed)),
                {2'($random(seed)), 21'($random(seed))});
        end
        $display("test access done");
        report_and_stop();
    end
endmodule : testbench
